// ### verilog/rx_input_map.svh
// Constants for the receive line input front end: reset values, counts and clock figures.
`ifndef RX_INPUT_MAP_SVH
`define RX_INPUT_MAP_SVH

// Internal clock rate in kHz (10 ns period).
`define RX_CLK_KHZ             100000
// Nominal byte clock rates in kHz for each receive rate.
`define RX_BYTE_CLK_STS1_KHZ   6480
`define RX_BYTE_CLK_STS3_KHZ   19440
// Byte clock period window in internal clock cycles, derived from the rates.
`define RX_STS1_MIN_CYC        (`RX_CLK_KHZ / `RX_BYTE_CLK_STS1_KHZ)
`define RX_STS1_MAX_CYC        ((`RX_CLK_KHZ + `RX_BYTE_CLK_STS1_KHZ - 1) / `RX_BYTE_CLK_STS1_KHZ)
`define RX_STS3_MIN_CYC        (`RX_CLK_KHZ / `RX_BYTE_CLK_STS3_KHZ)
`define RX_STS3_MAX_CYC        ((`RX_CLK_KHZ + `RX_BYTE_CLK_STS3_KHZ - 1) / `RX_BYTE_CLK_STS3_KHZ)
// Serial clock divide ratio and the last bit position of a byte.
`define RX_SERIAL_DIV          8
`define RX_LAST_BIT            3'h7
// Position of the first received bit inside a byte.
`define RX_FIRST_BIT_POS       7
// Reset values and the period counter saturation value.
`define RX_RST_BYTE            8'h00
`define RX_RST_BIT_CNT         3'h0
`define RX_RST_PERIOD          8'h00
`define RX_PERIOD_SAT          8'hff

`endif

// ### verilog/rx_input_pkg.sv
// Types shared by the receive line input front end.
package rx_input_pkg;

  // Which line input currently feeds the byte stream.
  typedef enum logic [1:0] {
    src_byte,
    src_differential,
    src_single_ended
  } source_t;

endpackage

// ### verilog/byte_fifo.sv
// Synchronous FIFO with a registered output stage and valid/ready on both sides.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Filling side.
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Draining side.
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push;
  logic             pop;

  // Pointer step with wrap, shared by both pointers.
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      step = '0;
    end else begin
      step = p + PW'(1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Full is honest: the output stage does not count as room, so a stalled
  // drain lets the memory reach DEPTH and refuse the filling side.
  always_comb begin
    o_in_ready     = (count != CW'(DEPTH));
    push           = i_in_valid && o_in_ready;
    pop            = (count != '0) && (!o_out_valid || i_out_ready);
    next_wr_ptr    = push ? step(wr_ptr) : wr_ptr;
    next_rd_ptr    = pop ? step(rd_ptr) : rd_ptr;
    next_count     = count + CW'(push) - CW'(pop);
    next_out_data  = pop ? mem[rd_ptr] : o_out_data;
    next_out_valid = pop ? 1'b1 : (i_out_ready ? 1'b0 : o_out_valid);
  end

  // Memory words carry no reset; only the pointers, count and output stage do.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // State registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      o_out_valid <= next_out_valid;
      o_out_data  <= next_out_data;
    end
  end

endmodule

// ### verilog/sonet_receive_line_input_select.sv
// Receive line input selection: byte-wide or bit-serial input to a byte stream.
//
// Operation
// - Strap high: use differential serial inputs
// - Strap low: use byte bus, clock, strobe
// - STS-1 serial may use single-ended input
// - Byte bus and strobe taken on clock rise
// - Byte clock tied to divided receive clock
// - Bus bit 7 is first bit sent
// - Bytes pass on still scrambled
// - Receive selection independent of transmit side
// - Strobe marks first payload envelope byte
// - Single-ended clock rise samples, divided by eight
// - Differential clock rise samples, divided by eight
`timescale 1ns/10ps
`include "rx_input_map.svh"
module sonet_receive_line_input_select #(
  parameter int unsigned BYTE_W     = 8,
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Receive configuration straps.
  input  wire logic              i_receive_interface_select,
  input  wire logic              i_receive_sts1_rate,
  input  wire logic              i_single_ended_select,
  // Byte-wide input.
  input  wire logic              i_receive_byte_clock,
  input  wire logic [BYTE_W-1:0] i_receive_byte_bus,
  input  wire logic              i_incoming_frame_position,
  // Single-ended bit-serial input.
  input  wire logic              i_single_ended_serial_input,
  input  wire logic              i_single_ended_serial_clock,
  // Differential bit-serial input.
  input  wire logic              i_differential_serial_data_p,
  input  wire logic              i_differential_serial_data_n,
  input  wire logic              i_differential_serial_clock_p,
  input  wire logic              i_differential_serial_clock_n,
  // Divided receive clock for the byte clock input.
  output logic                   o_divided_receive_clock_out,
  // Received byte stream.
  output logic                   o_receive_valid,
  input  wire logic              i_receive_ready,
  output logic      [BYTE_W-1:0] o_receive_byte,
  output logic                   o_receive_frame_position,
  // Status.
  input  wire logic              i_overflow_clear,
  output logic                   o_overflow,
  output logic                   o_byte_clock_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  rx_input_pkg::source_t source;
  rx_input_pkg::source_t next_source;
  rx_input_pkg::source_t picked;

  logic              byte_clk_prev;
  logic              serial_clk_prev;
  logic [2:0]        bit_cnt;
  logic [BYTE_W-1:0] shift;
  logic [BYTE_W-1:0] hold;
  logic              div_out;
  logic              overflow;
  logic [7:0]        period;
  logic              clock_fault;
  // Set once a whole serial byte has been assembled since the last source change.
  logic              hold_full;

  logic              next_byte_clk_prev;
  logic              next_serial_clk_prev;
  logic [2:0]        next_bit_cnt;
  logic [BYTE_W-1:0] next_shift;
  logic [BYTE_W-1:0] next_hold;
  logic              next_div_out;
  logic              next_overflow;
  logic [7:0]        next_period;
  logic              next_clock_fault;
  logic              next_hold_full;

  logic              serial_clk_lvl;
  logic              serial_data;
  logic              serial_rise;
  logic              byte_rise;
  logic              is_serial;
  logic [BYTE_W-1:0] shifted;
  logic              fifo_in_ready;
  logic              fifo_in_valid;
  logic [BYTE_W:0]   fifo_in_data;
  logic [BYTE_W:0]   fifo_out_data;
  logic              fifo_out_valid;
  logic [7:0]        measured;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Rising edge of a level that is sampled once per internal clock.
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  // Source choice from the straps. Single-ended only exists at the STS-1 rate,
  // so at the STS-3 rate the single-ended select is ignored.
  function automatic rx_input_pkg::source_t pick_source(input logic serial, input logic sts1,
                                                        input logic single);
    if (!serial) begin
      pick_source = rx_input_pkg::src_byte;
    end else if (sts1 && single) begin
      pick_source = rx_input_pkg::src_single_ended;
    end else begin
      pick_source = rx_input_pkg::src_differential;
    end
  endfunction

  // A differential pair reads high only when the two legs disagree that way;
  // an equal pair (open or shorted inputs) reads low rather than glitching.
  function automatic logic diff_level(input logic p, input logic n);
    diff_level = p && !n;
  endfunction

  // Byte clock period check for the selected receive rate.
  function automatic logic period_bad(input logic [7:0] cycles, input logic sts1);
    if (sts1) begin
      period_bad = (cycles < 8'(`RX_STS1_MIN_CYC)) || (cycles > 8'(`RX_STS1_MAX_CYC));
    end else begin
      period_bad = (cycles < 8'(`RX_STS3_MIN_CYC)) || (cycles > 8'(`RX_STS3_MAX_CYC));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input selection. The straps belong to the receive side alone, so they
  // can pick a mode unlike the transmit side's.
  // The straps are meant to be tied; a change mid-stream costs the byte in flight.
  always_comb begin
    picked      = pick_source(i_receive_interface_select, i_receive_sts1_rate,
                              i_single_ended_select);
    next_source = picked;
    is_serial   = (source != rx_input_pkg::src_byte);
    case (source)
      rx_input_pkg::src_single_ended: begin
        serial_clk_lvl = i_single_ended_serial_clock;
        serial_data    = i_single_ended_serial_input;
      end
      rx_input_pkg::src_differential: begin
        serial_clk_lvl = diff_level(i_differential_serial_clock_p,
                                    i_differential_serial_clock_n);
        serial_data    = diff_level(i_differential_serial_data_p,
                                    i_differential_serial_data_n);
      end
      default: begin
        serial_clk_lvl = 1'b0;
        serial_data    = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial assembly and divide by eight. A change of source restarts the
  // byte so no half-assembled byte from the old input leaks out.
  // The divided clock rises in the middle of the first group, before any
  // byte is complete, so that first rise must not hand on the holding byte.
  always_comb begin
    serial_rise          = rise(serial_clk_lvl, serial_clk_prev);
    next_serial_clk_prev = serial_clk_lvl;
    shifted              = {shift[BYTE_W-2:0], serial_data};
    next_shift           = shift;
    next_bit_cnt         = bit_cnt;
    next_hold            = hold;
    next_div_out         = div_out;
    next_hold_full       = hold_full;
    if (next_source != source) begin
      next_shift   = `RX_RST_BYTE;
      next_bit_cnt = `RX_RST_BIT_CNT;
      next_div_out = 1'b0;
      next_hold_full = 1'b0;
    end else if (is_serial && serial_rise) begin
      next_shift   = shifted;
      next_bit_cnt = bit_cnt + 3'h1;
      // The first bit has walked to the top after eight shifts.
      if (bit_cnt == `RX_LAST_BIT) begin
        next_hold = shifted;
        // From here on the holding byte is a real one.
        next_hold_full = 1'b1;
      end
      // High for the second half of each group of eight serial clocks.
      next_div_out = next_bit_cnt[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte capture on the byte clock rise. In serial modes the byte clock is
  // the divided clock fed back from outside; its rise comes four serial
  // clocks after the holding byte was loaded, so the byte is stable.
  always_comb begin
    byte_rise          = rise(i_receive_byte_clock, byte_clk_prev);
    next_byte_clk_prev = i_receive_byte_clock;
    // In serial modes a rise before the first complete byte would push a
    // stale holding byte left by an earlier source, so nothing is pushed
    // until one has been assembled.
    fifo_in_valid      = byte_rise && (!is_serial || hold_full);
    if (is_serial) begin
      fifo_in_data = {1'b0, hold};
    end else begin
      // Bit 7 is the first bit on the line; no reordering is done.
      // The frame strobe travels with the byte it marks.
      fifo_in_data = {i_incoming_frame_position, i_receive_byte_bus};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow: the line cannot be stalled, so a byte arriving while the FIFO
  // is full is dropped and remembered. A new drop wins over a clear.
  // Limitation: the flag tells that bytes were lost, not how many.
  always_comb begin
    next_overflow = overflow;
    if (i_overflow_clear) begin
      next_overflow = 1'b0;
    end
    if (fifo_in_valid && !fifo_in_ready) begin
      next_overflow = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte clock period monitor, byte mode only: the source must supply the
  // nominal rate for the chosen mode, and a byte clock that is off rate
  // usually means the rate strap and the source disagree.
  // Limitation: the first period after reset or a mode change starts at an
  // unrelated point, so one fault may show until the next good period.
  always_comb begin
    measured         = (period == `RX_PERIOD_SAT) ? period : period + 8'h01;
    next_period      = byte_rise ? 8'h00 : measured;
    next_clock_fault = clock_fault;
    if (!is_serial && byte_rise) begin
      next_clock_fault = period_bad(measured, i_receive_sts1_rate);
    end else if (is_serial) begin
      next_clock_fault = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  // All of them reset synchronously to constants, so the straps apply cleanly.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      source          <= rx_input_pkg::src_byte;
      byte_clk_prev   <= 1'b0;
      serial_clk_prev <= 1'b0;
      bit_cnt         <= `RX_RST_BIT_CNT;
      shift           <= `RX_RST_BYTE;
      hold            <= `RX_RST_BYTE;
      div_out         <= 1'b0;
      overflow        <= 1'b0;
      period          <= `RX_RST_PERIOD;
      clock_fault     <= 1'b0;
      hold_full       <= 1'b0;
    end else begin
      source          <= next_source;
      byte_clk_prev   <= next_byte_clk_prev;
      serial_clk_prev <= next_serial_clk_prev;
      bit_cnt         <= next_bit_cnt;
      shift           <= next_shift;
      hold            <= next_hold;
      div_out         <= next_div_out;
      overflow        <= next_overflow;
      period          <= next_period;
      clock_fault     <= next_clock_fault;
      hold_full       <= next_hold_full;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte buffer toward the receive processing. Bytes stay scrambled here;
  // descrambling follows frame alignment further on.
  // The depth trades area for how long the consumer may stall before bytes drop.
  byte_fifo #(
    .WIDTH (BYTE_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (i_receive_ready),
    .o_out_data  (fifo_out_data)
  );

  // Outputs, each from a flip-flop here or in the FIFO output stage.
  assign o_divided_receive_clock_out = div_out;
  assign o_receive_valid             = fifo_out_valid;
  assign o_receive_byte              = fifo_out_data[BYTE_W-1:0];
  assign o_receive_frame_position    = fifo_out_data[BYTE_W];
  assign o_overflow                  = overflow;
  assign o_byte_clock_fault          = clock_fault;

endmodule

// ### testbench/rx_input_assertions.sv
// Port-level checks for the receive line input front end.
`timescale 1ns/10ps
module rx_input_checker #(
  parameter int unsigned BYTE_W = 8
) (
  // Clock, reset and straps.
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_receive_interface_select,
  input wire logic              i_receive_sts1_rate,
  input wire logic              i_single_ended_select,
  // Line inputs.
  input wire logic              i_receive_byte_clock,
  input wire logic [BYTE_W-1:0] i_receive_byte_bus,
  input wire logic              i_incoming_frame_position,
  input wire logic              i_single_ended_serial_clock,
  input wire logic              i_differential_serial_clock_p,
  input wire logic              i_differential_serial_clock_n,
  // Outputs and handshake.
  input wire logic              o_divided_receive_clock_out,
  input wire logic              o_receive_valid,
  input wire logic              i_receive_ready,
  input wire logic [BYTE_W-1:0] o_receive_byte,
  input wire logic              o_receive_frame_position,
  input wire logic              i_overflow_clear,
  input wire logic              o_overflow,
  input wire logic              o_byte_clock_fault
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  // Serial clock rises since the last divided clock rise; leaving serial mode restarts it.
  logic       sclk;
  logic       sclk_q;
  logic       srise;
  logic       div_q;
  logic       seen;
  logic [3:0] rc;
  assign sclk  = (i_single_ended_select && i_receive_sts1_rate) ? i_single_ended_serial_clock
                 : (i_differential_serial_clock_p & ~i_differential_serial_clock_n);
  assign srise = sclk & ~sclk_q;
  always_ff @(posedge i_clk) begin
    sclk_q <= sclk;
    div_q  <= o_divided_receive_clock_out;
    if (!i_rst_n || !i_receive_interface_select) begin
      rc   <= 4'h0;
      seen <= 1'b0;
    end else if (o_divided_receive_clock_out && !div_q) begin
      rc   <= {3'h0, srise};
      seen <= 1'b1;
    end else if (srise) begin
      rc <= rc + 4'h1;
    end
  end
  ////////////////////////////////////////
  a_byte_capture: assert property (
    (!i_receive_interface_select && !o_receive_valid)[*3] ##0 $rose(i_receive_byte_clock)
    |-> ##2 o_receive_valid && o_receive_byte == $past(i_receive_byte_bus, 2)
    && o_receive_frame_position == $past(i_incoming_frame_position, 2))
    else $error("byte not delivered two cycles after capture");
  a_output_hold: assert property (
    o_receive_valid && !i_receive_ready |=> o_receive_valid && $stable(o_receive_byte)
    && $stable(o_receive_frame_position))
    else $error("output changed while stalled");
  a_divider_idle: assert property (
    (!i_receive_interface_select)[*4] |-> !o_divided_receive_clock_out)
    else $error("divided clock active in byte mode");
  a_fault_serial: assert property (
    i_receive_interface_select[*4] |-> !o_byte_clock_fault)
    else $error("clock fault raised in serial mode");
  a_divide_eight: assert property (
    i_receive_interface_select && seen && $rose(o_divided_receive_clock_out) |-> rc == 4'h8)
    else $error("divided clock not one rise in eight");
  a_overflow_sticky: assert property (
    o_overflow && !i_overflow_clear |=> o_overflow)
    else $error("overflow dropped without clear");
  a_overflow_clear: assert property (
    i_overflow_clear && !o_receive_valid |=> !o_overflow)
    else $error("overflow not cleared");
  a_overflow_cause: assert property (
    $rose(o_overflow) |-> $past(o_receive_valid))
    else $error("overflow without a full buffer");
endmodule

// ### testbench/line_source_model.sv
// Line-side source model: byte-wide stream or bit-serial stream with its clock.
`timescale 1ns/10ps
module line_source_model (
  // Clock and loop-back.
  input  wire logic       i_clk,
  input  wire logic       i_serial,
  input  wire logic       i_divided_clock,
  // Byte-wide lines.
  output logic            o_byte_clock,
  output logic      [7:0] o_byte_bus,
  output logic            o_frame_position,
  // Serial lines.
  output logic            o_se_data,
  output logic            o_se_clock,
  output logic            o_diff_data_p,
  output logic            o_diff_data_n,
  output logic            o_diff_clock_p,
  output logic            o_diff_clock_n
);
  logic bclk;
  logic sdat;
  logic sclk;
  logic use_se;
  ////////////////////////////////////////
  // Serial capture needs the byte clock looped back from the divided clock.
  assign o_byte_clock   = i_serial ? i_divided_clock : bclk;
  // The unused serial input rests low, as a pulled-down pin would.
  assign o_se_data      = use_se & sdat;
  assign o_se_clock     = use_se & sclk;
  assign o_diff_data_p  = ~use_se & sdat;
  assign o_diff_data_n  = ~o_diff_data_p;
  assign o_diff_clock_p = ~use_se & sclk;
  assign o_diff_clock_n = ~o_diff_clock_p;
  // Quiet lines until the first transfer.
  initial begin
    {bclk, sdat, sclk, use_se, o_frame_position} = 5'h00;
    o_byte_bus = 8'h00;
  end
  // One byte per rise, first line bit on bit 7, still scrambled; after the high phase
  // the lines show the complement so a capture on the wrong edge cannot pass by luck.
  task automatic send_byte(input logic [7:0] b, input logic fp, input int hi, input int lo);
    o_byte_bus       <= b;
    o_frame_position <= fp;
    bclk             <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_byte_bus       <= ~b;
    o_frame_position <= ~fp;
    bclk             <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask
  // Eight bits, first bit first; the clock stands low between bytes.
  task automatic send_serial(input logic [7:0] b, input logic se);
    use_se <= se;
    for (int i = 7; i >= 0; i--) begin
      sdat <= b[i];
      sclk <= 1'b1;
      repeat (2) @(posedge i_clk);
      sdat <= ~b[i];
      sclk <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the receive line input front end.
`timescale 1ns/10ps
module testbench;
  logic       clk, rst_n, sel, sts1, se, ready, oclr, stall;
  logic       bclk, fpin, se_d, se_c, dp, dn, cp, cn, div, valid, ofp, ovf, fault;
  logic [7:0] bus, obyte;
  logic [8:0] expq[$];
  int         miscompares, samples_checked;
  sonet_receive_line_input_select DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_receive_interface_select(sel), .i_receive_sts1_rate(sts1),
    .i_single_ended_select(se), .i_receive_byte_clock(bclk), .i_receive_byte_bus(bus),
    .i_incoming_frame_position(fpin), .i_single_ended_serial_input(se_d),
    .i_single_ended_serial_clock(se_c), .i_differential_serial_data_p(dp),
    .i_differential_serial_data_n(dn), .i_differential_serial_clock_p(cp),
    .i_differential_serial_clock_n(cn), .o_divided_receive_clock_out(div), .o_receive_valid(valid),
    .i_receive_ready(ready), .o_receive_byte(obyte), .o_receive_frame_position(ofp),
    .i_overflow_clear(oclr), .o_overflow(ovf), .o_byte_clock_fault(fault));
  line_source_model src (
    .i_clk(clk), .i_serial(sel), .i_divided_clock(div), .o_byte_clock(bclk), .o_byte_bus(bus),
    .o_frame_position(fpin), .o_se_data(se_d), .o_se_clock(se_c), .o_diff_data_p(dp),
    .o_diff_data_n(dn), .o_diff_clock_p(cp), .o_diff_clock_n(cn));
  ////////////////////////////////////////
  // Clock and a randomly hesitant consumer.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) ready <= !stall && ($urandom_range(3) != 0);
  // Each byte leaving the block must be the oldest one expected.
  always @(posedge clk) begin
    if (rst_n && valid === 1'b1 && ready === 1'b1) begin
      check(expq.size() > 0 && {ofp, obyte} === expq[0], "wrong byte or frame tag");
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic set_mode(input logic s, input logic r, input logic e);
    sel  <= s;
    sts1 <= r;
    se   <= e;
    repeat (4) @(posedge clk);
  endtask
  task automatic byte_in(input logic [7:0] b, input logic fp, input int hi, input int lo, input bit keep);
    if (keep) expq.push_back({fp, b});
    src.send_byte(b, fp, hi, lo);
  endtask
  // Serial bytes carry no frame mark; framing is done further on.
  task automatic ser_in(input logic [7:0] b, input logic s, input bit keep);
    if (keep) expq.push_back({1'b0, b});
    src.send_serial(b, s);
  endtask
  task automatic drain();
    for (int n = 0; n < 3000 && expq.size() > 0; n++) @(posedge clk);
    check(expq.size() == 0, "stream incomplete");
    repeat (4) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    {rst_n, sel, se, ready, oclr, stall} = 6'h00;
    sts1 = 1'b1;
    void'($urandom(32'h0362d915));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Lower rate byte-wide stream at periods 15 and 16.
    set_mode(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 24; i++) byte_in(8'($urandom), 1'($urandom), 8, 7 + i % 2, 1'b1);
    drain();
    check(fault === 1'b0, "fault at nominal rate");
    $display("test byte_low_rate done");
    // Consumer stalled: 16 words plus the output stage are kept, later bytes drop.
    set_mode(1'b0, 1'b0, 1'b0);
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) byte_in(8'($urandom), 1'($urandom), 3, 2 + i % 2, i < 17);
    check(ovf === 1'b1, "overflow not flagged");
    stall <= 1'b0;
    drain();
    oclr <= 1'b1;
    @(posedge clk);
    oclr <= 1'b0;
    @(posedge clk);
    check(ovf === 1'b0, "overflow not cleared");
    $display("test overflow done");
    // A byte clock far below the higher rate must be flagged.
    for (int i = 0; i < 3; i++) byte_in(8'($urandom), 1'b0, 5, 5, 1'b1);
    drain();
    check(fault === 1'b1, "slow byte clock not flagged");
    $display("test slow_clock done");
    // Differential serial input; the single-ended strap is ignored at the higher rate.
    set_mode(1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 7; i++) ser_in(8'($urandom), 1'b0, i < 6);
    drain();
    check(fault === 1'b0, "fault in serial mode");
    $display("test differential done");
    // Single-ended serial input at the lower rate.
    set_mode(1'b0, 1'b1, 1'b1);
    set_mode(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 7; i++) ser_in(8'($urandom), 1'b1, i < 6);
    drain();
    $display("test single_ended done");
    conclude();
  end
  // Watchdog well beyond the roughly one thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule

bind sonet_receive_line_input_select rx_input_checker #(.BYTE_W(BYTE_W)) checker_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_receive_interface_select(i_receive_interface_select),
  .i_receive_sts1_rate(i_receive_sts1_rate), .i_single_ended_select(i_single_ended_select),
  .i_receive_byte_clock(i_receive_byte_clock), .i_receive_byte_bus(i_receive_byte_bus),
  .i_incoming_frame_position(i_incoming_frame_position),
  .i_single_ended_serial_clock(i_single_ended_serial_clock),
  .i_differential_serial_clock_p(i_differential_serial_clock_p),
  .i_differential_serial_clock_n(i_differential_serial_clock_n),
  .o_divided_receive_clock_out(o_divided_receive_clock_out), .o_receive_valid(o_receive_valid),
  .i_receive_ready(i_receive_ready), .o_receive_byte(o_receive_byte),
  .o_receive_frame_position(o_receive_frame_position), .i_overflow_clear(i_overflow_clear),
  .o_overflow(o_overflow), .o_byte_clock_fault(o_byte_clock_fault));
